// ---- csr_checker.sv ----
// concurrent checks on the ports of the conversion signal routing block
// assumes binding to csr_routing, one clock domain, apb writes shadowed here
`timescale 1ns/1ps
`default_nettype none
module csr_checker
   import csr_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] backplane_connector_out,
   input wire logic [2:0] backplane_connector_oe_b,
   input wire logic [7:0] front_digital_pin_out,
   input wire logic [7:0] front_digital_pin_oe_b,
   input wire logic [7:0] dio_output_enable,
   input wire logic [7:0] dio_output_value
);
   logic [1:0] up_reg;
   logic [2:0] en_reg;
   logic [5:0] drv_reg;
   logic wr;
   assign wr = psel && penable && pready && pwrite;
   // ---
   // shadow of enable and driver fields
   // ---
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         up_reg <= 2'h0;
         en_reg <= 3'h0;
         drv_reg <= 6'h0;
      end else begin
         up_reg <= (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
         if (wr && paddr == CSR_ENABLE_ADDR) en_reg <= {pwdata[8], pwdata[1:0]};
         if (wr && paddr == CSR_DRIVER_ADDR) drv_reg <= pwdata[5:0];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence s_access;
      psel && !penable ##1 psel && penable;
   endsequence
   AST_ONE_WAIT: assert property (s_access |=> pready)
      else $error("no answer one cycle after access");
   AST_PREADY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_NO_ERROR: assert property (pready |-> !pslverr)
      else $error("error response seen");
   AST_CLK1_HIGH: assert property ((!en_reg[0]) [*3] |-> backplane_connector_out[0])
      else $error("first clock not high while disabled");
   AST_CLK2_HIGH: assert property ((!en_reg[1]) [*3] |-> backplane_connector_out[1])
      else $error("second clock not high while disabled");
   AST_TRIG_HIGH: assert property ((!en_reg[2]) [*3] |-> backplane_connector_out[2])
      else $error("trigger not high while disabled");
   AST_TRIG_NEEDS_CLK: assert property ((!en_reg[0] && !en_reg[1]) [*3]
      |-> !$fell(backplane_connector_out[2])) else $error("trigger without clock");
   AST_BACK_DRIVE: assert property ((drv_reg[1:0] == 2'h2) [*2]
      |-> !backplane_connector_oe_b[0]) else $error("backplane line not driven");
   AST_BACK_OFF: assert property ((!drv_reg[1]) [*2] |-> backplane_connector_oe_b[0])
      else $error("backplane line driven while off");
   AST_FRONT_ROUTE: assert property ((drv_reg[5:4] == 2'h3 && !dio_output_enable[4]) [*2]
      |-> !front_digital_pin_oe_b[4]) else $error("front pin not driven");
   AST_FRONT_OVERRIDE: assert property ((up_reg == 2'h3 && dio_output_enable[0]) [*2]
      |-> !front_digital_pin_oe_b[0] && front_digital_pin_out[0] == $past(dio_output_value[0]))
      else $error("general output not dominant");
endmodule
bind csr_routing csr_checker u_chk (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .pslverr, .backplane_connector_out, .backplane_connector_oe_b,
   .front_digital_pin_out, .front_digital_pin_oe_b, .dio_output_enable, .dio_output_value);
`default_nettype wire

// ---- csr_peer.sv ----
// peer boards on the shared backplane and front conversion lines
// assumes a pull-up on every shared line
`timescale 1ns/1ps
`default_nettype none
module csr_peer (
   input wire logic peer_drive,
   input wire logic [2:0] peer_bp,
   input wire logic [7:0] peer_fp,
   input wire logic [2:0] bp_out,
   input wire logic [2:0] bp_oe_b,
   input wire logic [7:0] fp_out,
   input wire logic [7:0] fp_oe_b,
   output logic [2:0] bp_line,
   output logic [7:0] fp_line
);
   // master peer drives, released lines float up
   assign bp_line = (~bp_oe_b & bp_out) | (bp_oe_b & (peer_drive ? peer_bp : 3'h7));
   assign fp_line = (~fp_oe_b & fp_out) | (fp_oe_b & (peer_drive ? peer_fp : 8'hff));
endmodule
`default_nettype wire

// ---- csr_pkg.sv ----
// constants and types for the conversion signal routing block
// assumes a 200 MHz system clock and an APB master with 32-bit data
package csr_pkg;
   localparam logic [11:0] CSR_ENABLE_ADDR = 12'h33c;
   localparam logic [11:0] CSR_DRIVER_ADDR = 12'h340;
   localparam logic [11:0] CSR_SOURCE_ADDR = 12'h344;
   localparam logic [11:0] CSR_CLK1_ADDR = 12'h320;
   localparam logic [11:0] CSR_CLK2_ADDR = 12'h324;
   localparam logic [11:0] CSR_TRIG1_ADDR = 12'h32c;
   localparam logic [11:0] CSR_TRIG2_ADDR = 12'h330;
   localparam int CSR_EN_CLK1_BIT = 0;
   localparam int CSR_EN_CLK2_BIT = 1;
   localparam int CSR_EN_TRIG_BIT = 8;
   localparam logic [31:0] CSR_ENABLE_MASK = 32'h0000_0103;
   localparam logic [31:0] CSR_ROUTE_MASK = 32'h0000_003f;
   localparam logic [31:0] CSR_CLKGEN_MASK = 32'h6fff_ffff;
   localparam logic [31:0] CSR_TRIG1_MASK = 32'h2fff_ffff;
   localparam logic [31:0] CSR_TRIG2_MASK = 32'h0fff_ffff;
   localparam logic [31:0] CSR_CLKGEN_RESET = 32'h0fff_ffff;
   localparam logic [31:0] CSR_TRIG1_RESET = 32'h0fff_ffff;
   localparam int CSR_DIV_MSB = 27;
   localparam int CSR_ISRC_LSB = 29;
   localparam int CSR_TSRC_BIT = 29;
   localparam logic [1:0] CSR_ROUTE_BACK = 2'h2;
   localparam logic [1:0] CSR_ROUTE_FRONT = 2'h3;
   localparam int CSR_PIN_CLK1 = 0;
   localparam int CSR_PIN_CLK2 = 2;
   localparam int CSR_PIN_TRIG = 4;
endpackage

// ---- csr_routing.sv ----
// conversion clock and frame trigger generation and routing, APB slave
// assumes 20/22.05/60 MHz source ticks arrive as clock-domain strobes
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module csr_routing
   import csr_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] src_tick,
   input wire logic [2:0] backplane_connector_in,
   output logic [2:0] backplane_connector_out,
   output logic [2:0] backplane_connector_oe_b,
   input wire logic [7:0] front_digital_pin_in,
   output logic [7:0] front_digital_pin_out,
   output logic [7:0] front_digital_pin_oe_b,
   input wire logic [7:0] dio_output_enable,
   input wire logic [7:0] dio_output_value,
   output logic [2:0] conversion_signal
);
   typedef struct packed {
      logic [31:0] enable_reg;
      logic [31:0] driver_reg;
      logic [31:0] source_reg;
      logic [31:0] clk1_reg;
      logic [31:0] clk2_reg;
      logic [31:0] trig1_reg;
      logic [31:0] trig2_reg;
      logic [5:0] in_s1;
      logic [5:0] in_s2;
      logic [2:0] tick_s1;
      logic [2:0] tick_s2;
      logic [27:0] div1;
      logic [27:0] div2;
      logic [27:0] tdiv;
      logic [27:0] tleft;
      logic tdone;
      logic gen1;
      logic gen2;
      logic gtrig;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [2:0] bp_out;
      logic [2:0] bp_oe_b;
      logic [7:0] fp_out;
      logic [7:0] fp_oe_b;
      logic [2:0] conv;
   } csr_state_t;

   csr_state_t s_reg, s_next;
   logic [1:0] rst_sync_reg;
   logic rst_int_b;

   // synchroniser kept apart: it resets on the raw pin, the state on its copy
   assign rst_int_b = rst_sync_reg[1];

   // pick a source tick by two-bit internal source code; code 11 gives no tick
   function automatic logic pick_tick(input logic [1:0] code, input logic [2:0] t);
      pick_tick = (code == 2'h3) ? 1'b0 : t[code];
   endfunction

   // decode one source field: local, backplane line or front pin
   function automatic logic pick_src(input logic [1:0] code, input logic local_sig,
                                     input logic bp, input logic fp);
      if (code == CSR_ROUTE_BACK) begin
         pick_src = bp;
      end else if (code == CSR_ROUTE_FRONT) begin
         pick_src = fp;
      end else begin
         pick_src = local_sig;
      end
   endfunction

   // -----------------------------------------------------------------
   // reset release
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      logic acc;
      logic wr;
      logic t1;
      logic t2;
      logic edge_sel;
      logic g1_was;
      logic g2_was;
      logic [2:0] gen_sig;
      logic [2:0] route;
      logic [1:0] f;
      logic [2:0] pin;
      int k;
      acc = psel && penable && s_reg.pready;
      wr = acc && pwrite;
      t1 = 1'b0;
      t2 = 1'b0;
      edge_sel = 1'b0;
      g1_was = 1'b1;
      g2_was = 1'b1;
      gen_sig = 3'h7;
      route = 3'h7;
      f = 2'h0;
      pin = 3'h0;
      k = 0;
      s_next = s_reg;
      s_next.in_s1 = {backplane_connector_in, front_digital_pin_in[4], front_digital_pin_in[2],
                      front_digital_pin_in[0]};
      s_next.in_s2 = s_reg.in_s1;
      s_next.tick_s1 = src_tick;
      s_next.tick_s2 = s_reg.tick_s1;

      // apb slave: one wait state, pready pulses in the access phase
      s_next.pready = psel && penable && !s_reg.pready;
      s_next.pslverr = 1'b0;
      if (psel && penable && !s_reg.pready && !pwrite) begin
         unique case (paddr)
            CSR_ENABLE_ADDR: s_next.prdata = s_reg.enable_reg;
            CSR_DRIVER_ADDR: s_next.prdata = s_reg.driver_reg;
            CSR_SOURCE_ADDR: s_next.prdata = s_reg.source_reg;
            CSR_CLK1_ADDR: s_next.prdata = s_reg.clk1_reg;
            CSR_CLK2_ADDR: s_next.prdata = s_reg.clk2_reg;
            CSR_TRIG1_ADDR: s_next.prdata = s_reg.trig1_reg;
            CSR_TRIG2_ADDR: s_next.prdata = s_reg.trig2_reg;
            default: s_next.prdata = 32'h0;
         endcase
      end
      if (wr) begin
         unique case (paddr)
            CSR_ENABLE_ADDR: s_next.enable_reg = pwdata & CSR_ENABLE_MASK;
            CSR_DRIVER_ADDR: s_next.driver_reg = pwdata & CSR_ROUTE_MASK;
            CSR_SOURCE_ADDR: s_next.source_reg = pwdata & CSR_ROUTE_MASK;
            CSR_CLK1_ADDR: s_next.clk1_reg = pwdata & CSR_CLKGEN_MASK;
            CSR_CLK2_ADDR: s_next.clk2_reg = pwdata & CSR_CLKGEN_MASK;
            CSR_TRIG1_ADDR: s_next.trig1_reg = pwdata & CSR_TRIG1_MASK;
            CSR_TRIG2_ADDR: s_next.trig2_reg = pwdata & CSR_TRIG2_MASK;
            default: s_next.enable_reg = s_reg.enable_reg;
         endcase
      end

      // -----------------------------------------------------------------
      // clock generators: toggle every divider+1 source ticks
      // -----------------------------------------------------------------
      g1_was = s_reg.gen1;
      g2_was = s_reg.gen2;
      t1 = pick_tick(s_reg.clk1_reg[CSR_ISRC_LSB+1:CSR_ISRC_LSB], s_reg.tick_s2);
      t2 = pick_tick(s_reg.clk2_reg[CSR_ISRC_LSB+1:CSR_ISRC_LSB], s_reg.tick_s2);
      if (!s_reg.enable_reg[CSR_EN_CLK1_BIT]) begin
         s_next.gen1 = 1'b1;
         s_next.div1 = 28'h0;
      end else if (t1) begin
         if (s_reg.div1 >= s_reg.clk1_reg[CSR_DIV_MSB:0]) begin
            s_next.div1 = 28'h0;
            s_next.gen1 = !s_reg.gen1;
         end else begin
            s_next.div1 = s_reg.div1 + 28'h1;
         end
      end
      if (!s_reg.enable_reg[CSR_EN_CLK2_BIT]) begin
         s_next.gen2 = 1'b1;
         s_next.div2 = 28'h0;
      end else if (t2) begin
         if (s_reg.div2 >= s_reg.clk2_reg[CSR_DIV_MSB:0]) begin
            s_next.div2 = 28'h0;
            s_next.gen2 = !s_reg.gen2;
         end else begin
            s_next.div2 = s_reg.div2 + 28'h1;
         end
      end

      // -----------------------------------------------------------------
      // frame trigger generator: low pulse of one selected clock period
      // -----------------------------------------------------------------
      edge_sel = s_reg.trig1_reg[CSR_TSRC_BIT] ? (s_next.gen2 && !g2_was)
                                               : (s_next.gen1 && !g1_was);
      if (!s_reg.enable_reg[CSR_EN_TRIG_BIT]) begin
         s_next.gtrig = 1'b1;
         s_next.tdiv = 28'h0;
         s_next.tleft = s_reg.trig2_reg[CSR_DIV_MSB:0];
         s_next.tdone = 1'b0;
      end else if (edge_sel) begin
         s_next.gtrig = 1'b1;
         if (s_reg.tdiv == 28'h0 && !s_reg.tdone) begin
            s_next.gtrig = 1'b0;
            if (s_reg.trig2_reg[CSR_DIV_MSB:0] != 28'h0) begin
               s_next.tleft = s_reg.tleft - 28'h1;
               s_next.tdone = (s_reg.tleft == 28'h1);
            end
         end
         if (s_reg.tdiv >= s_reg.trig1_reg[CSR_DIV_MSB:0]) begin
            s_next.tdiv = 28'h0;
         end else begin
            s_next.tdiv = s_reg.tdiv + 28'h1;
         end
      end

      // -----------------------------------------------------------------
      // routing of outputs and sources
      // -----------------------------------------------------------------
      gen_sig = {s_reg.gtrig, s_reg.gen2, s_reg.gen1};
      s_next.bp_out = gen_sig;
      s_next.fp_out = dio_output_value;
      s_next.fp_oe_b = ~dio_output_enable;
      s_next.bp_oe_b = 3'h7;
      for (k = 0; k < 3; k++) begin
         f = s_reg.driver_reg[2*k +: 2];
         pin = 3'(2*k);
         route[k] = pick_src(s_reg.source_reg[2*k +: 2], gen_sig[k], s_reg.in_s2[3+k],
                             s_reg.in_s2[k]);
         if (f == CSR_ROUTE_BACK) begin
            s_next.bp_oe_b[k] = 1'b0;
         end
         if (f == CSR_ROUTE_FRONT && !dio_output_enable[pin]) begin
            s_next.fp_oe_b[pin] = 1'b0;
            s_next.fp_out[pin] = gen_sig[k];
         end
      end
      s_next.conv = route;
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_int_b) begin
      if (!rst_int_b) begin
         s_reg.enable_reg <= 32'h0;
         s_reg.driver_reg <= 32'h0;
         s_reg.source_reg <= 32'h0;
         s_reg.clk1_reg <= CSR_CLKGEN_RESET;
         s_reg.clk2_reg <= CSR_CLKGEN_RESET;
         s_reg.trig1_reg <= CSR_TRIG1_RESET;
         s_reg.trig2_reg <= 32'h0;
         s_reg.in_s1 <= 6'h0;
         s_reg.in_s2 <= 6'h0;
         s_reg.tick_s1 <= 3'h0;
         s_reg.tick_s2 <= 3'h0;
         s_reg.div1 <= 28'h0;
         s_reg.div2 <= 28'h0;
         s_reg.tdiv <= 28'h0;
         s_reg.tleft <= 28'h0;
         s_reg.tdone <= 1'b0;
         s_reg.gen1 <= 1'b1;
         s_reg.gen2 <= 1'b1;
         s_reg.gtrig <= 1'b1;
         s_reg.prdata <= 32'h0;
         s_reg.pready <= 1'b0;
         s_reg.pslverr <= 1'b0;
         s_reg.bp_out <= 3'h7;
         s_reg.bp_oe_b <= 3'h7;
         s_reg.fp_out <= 8'h0;
         s_reg.fp_oe_b <= 8'hff;
         s_reg.conv <= 3'h7;
      end else begin
         s_reg.enable_reg <= s_next.enable_reg;
         s_reg.driver_reg <= s_next.driver_reg;
         s_reg.source_reg <= s_next.source_reg;
         s_reg.clk1_reg <= s_next.clk1_reg;
         s_reg.clk2_reg <= s_next.clk2_reg;
         s_reg.trig1_reg <= s_next.trig1_reg;
         s_reg.trig2_reg <= s_next.trig2_reg;
         s_reg.in_s1 <= s_next.in_s1;
         s_reg.in_s2 <= s_next.in_s2;
         s_reg.tick_s1 <= s_next.tick_s1;
         s_reg.tick_s2 <= s_next.tick_s2;
         s_reg.div1 <= s_next.div1;
         s_reg.div2 <= s_next.div2;
         s_reg.tdiv <= s_next.tdiv;
         s_reg.tleft <= s_next.tleft;
         s_reg.tdone <= s_next.tdone;
         s_reg.gen1 <= s_next.gen1;
         s_reg.gen2 <= s_next.gen2;
         s_reg.gtrig <= s_next.gtrig;
         s_reg.prdata <= s_next.prdata;
         s_reg.pready <= s_next.pready;
         s_reg.pslverr <= s_next.pslverr;
         s_reg.bp_out <= s_next.bp_out;
         s_reg.bp_oe_b <= s_next.bp_oe_b;
         s_reg.fp_out <= s_next.fp_out;
         s_reg.fp_oe_b <= s_next.fp_oe_b;
         s_reg.conv <= s_next.conv;
      end
   end

   // -----------------------------------------------------------------
   // outputs, all straight from the state register
   // -----------------------------------------------------------------
   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign backplane_connector_out = s_reg.bp_out;
   assign backplane_connector_oe_b = s_reg.bp_oe_b;
   assign front_digital_pin_out = s_reg.fp_out;
   assign front_digital_pin_oe_b = s_reg.fp_oe_b;
   assign conversion_signal = s_reg.conv;
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for csr_routing over apb
// assumes csr_peer on the shared lines and csr_checker bound to the dut
`timescale 1ns/1ps
`default_nettype none
module testbench import csr_pkg::*;;
   logic clock = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic pready, pslverr, peer_drive = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [2:0] src_tick = 3'h0, bp_in, bp_out, bp_oe_b, cs;
   logic [7:0] fp_in, fp_out, fp_oe_b, dio_en = 8'h0, dio_val = 8'h0;
   logic [11:0] ra [3] = '{CSR_ENABLE_ADDR, CSR_DRIVER_ADDR, CSR_SOURCE_ADDR};
   logic [31:0] rm [3] = '{32'h103, 32'h3f, 32'h3f};
   int fails = 0, samples_checked = 0, cyc = 0, nf = 0, nr0 = 0, nr1 = 0;
   csr_routing dut (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .src_tick, .backplane_connector_in(bp_in),
      .backplane_connector_out(bp_out), .backplane_connector_oe_b(bp_oe_b),
      .front_digital_pin_in(fp_in), .front_digital_pin_out(fp_out),
      .front_digital_pin_oe_b(fp_oe_b), .dio_output_enable(dio_en),
      .dio_output_value(dio_val), .conversion_signal(cs));
   csr_peer peer (.peer_drive, .peer_bp(3'h2), .peer_fp(8'h11), .bp_out, .bp_oe_b, .fp_out,
      .fp_oe_b, .bp_line(bp_in), .fp_line(fp_in));
   initial begin
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      src_tick <= ~src_tick;
      cyc++;
      if ($fell(cs[2])) nf++;
      if ($rose(cs[0])) nr0++;
      if ($rose(cs[1])) nr1++;
      if (cyc == 5000) begin
         fails++;
         end_of_test;
      end
   end
   // ---
   // apb access and checking
   // ---
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'h1 && n < 20);
      q = prdata;
      if (n == 20) fails++;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'h0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge clock);
   endtask
   task automatic zero;
      @(negedge clock);
      nf = 0;
      nr0 = 0;
      nr1 = 0;
      @(posedge clock);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ---
   // main sequence
   // ---
   initial begin
      repeat (10) @(posedge clock);
      rst_b <= 1'h1;
      idle(4);
      foreach (ra[i]) rd(ra[i], 32'h0);
      foreach (ra[i]) begin
         xfer(1'h1, ra[i], 32'hffff_ffff);
         rd(ra[i], rm[i]);
         xfer(1'h1, ra[i], 32'h0);
      end
      rd(12'h000, 32'h0);
      xfer(1'h1, CSR_CLK1_ADDR, 32'h0);
      xfer(1'h1, CSR_CLK2_ADDR, 32'h0);
      xfer(1'h1, CSR_TRIG1_ADDR, 32'h1);
      xfer(1'h1, CSR_TRIG2_ADDR, 32'h3);
      zero;
      xfer(1'h1, CSR_ENABLE_ADDR, 32'h103);
      idle(200);
      chk(nf, 32'h3);
      chk(nr0 == nr1 && nr0 > 40, 32'h1);
      xfer(1'h1, CSR_ENABLE_ADDR, 32'h0);
      idle(8);
      chk(cs, 3'h7);
      xfer(1'h1, CSR_TRIG2_ADDR, 32'h0);
      xfer(1'h1, CSR_TRIG1_ADDR, 32'h2000_0001);
      zero;
      xfer(1'h1, CSR_ENABLE_ADDR, 32'h101);
      idle(100);
      chk(nf, 32'h0);
      xfer(1'h1, CSR_ENABLE_ADDR, 32'h103);
      idle(200);
      chk(nf > 8, 32'h1);
      xfer(1'h1, CSR_ENABLE_ADDR, 32'h0);
      for (int c = 0; c < 4; c++) begin
         xfer(1'h1, CSR_DRIVER_ADDR, {26'h0, c[1:0], c[1:0], c[1:0]});
         idle(3);
         chk(bp_oe_b, c == 2 ? 3'h0 : 3'h7);
         chk(fp_oe_b, c == 3 ? 8'hea : 8'hff);
      end
      dio_val <= 8'h44;
      dio_en <= 8'h45;
      idle(3);
      chk(fp_oe_b, 8'haa);
      chk(fp_out & 8'h55, 8'h54);
      dio_en <= 8'h0;
      xfer(1'h1, CSR_DRIVER_ADDR, 32'h0);
      peer_drive <= 1'h1;
      for (int c = 0; c < 4; c++) begin
         xfer(1'h1, CSR_SOURCE_ADDR, {26'h0, c[1:0], c[1:0], c[1:0]});
         idle(5);
         chk(cs, c < 2 ? 3'h7 : (c == 2 ? 3'h2 : 3'h5));
      end
      peer_drive <= 1'h0;
      idle(5);
      chk(cs, 3'h7);
      end_of_test;
   end
endmodule
`default_nettype wire
